/* File: design/option_pkg.sv */
// option_pkg: addresses, bit positions, factory values and timing counts
// assumes a 16-bit cpu address space with 8-bit data
package option_pkg;
  localparam logic [15:0] ADDR_GENERAL_A  = 16'h001f;
  localparam logic [15:0] ADDR_GENERAL_B  = 16'h003f;
  localparam logic [15:0] ADDR_DIV_HIGH   = 16'hfe10;
  localparam logic [15:0] ADDR_DIV_LOW    = 16'hfe11;
  localparam logic [15:0] ADDR_NVM_CONFIG = 16'hfe1c;
  // read/write divider pair; placement is a local choice, kept off the option bytes
  localparam logic [15:0] ADDR_DIVIDER_REG_HIGH = 16'hfe12;
  localparam logic [15:0] ADDR_DIVIDER_REG_LOW  = 16'hfe13;
  // factory-programmed content of the nvm configuration byte
  localparam logic [7:0]  NVM_CONFIG_RESET      = 8'h10;
  // general_option_a bit positions
  localparam int BIT_SUPERVISOR_IN_STOP       = 7;
  localparam int BIT_ROM_PROTECT              = 6;
  localparam int BIT_SUPERVISOR_RESET_DISABLE = 5;
  localparam int BIT_SUPERVISOR_POWER_DISABLE = 4;
  localparam int BIT_SHORT_RECOVERY           = 3;
  localparam int BIT_WATCHDOG_RATE            = 2;
  localparam int BIT_STOP_ENABLE              = 1;
  localparam int BIT_WATCHDOG_DISABLE         = 0;
  // general_option_b bit positions
  localparam int BIT_DIVIDER_CLOCK_SELECT     = 7;
  localparam int BIT_NVM_SECURITY_ENABLE      = 6;
  localparam int BIT_MONITOR_NVM_SECURITY     = 5;
  // nvm configuration byte: protect bit position
  localparam int BIT_NVM_PROTECT              = 4;
  // factory values; arbitrary defaults, set per ordered part
  localparam logic [7:0] GENERAL_A_VALUE  = 8'h00;
  localparam logic [7:0] GENERAL_B_VALUE  = 8'h00;
  localparam logic [7:0] DIV_HIGH_VALUE   = 8'h80;
  localparam logic [7:0] DIV_LOW_VALUE    = 8'hac;
  // recovery and watchdog counts, in oscillator-derived clock cycles
  localparam int RECOVERY_SHORT_CYCLES = 32;
  localparam int RECOVERY_LONG_CYCLES  = 4096;
  localparam int WATCHDOG_LONG_CYCLES  = (2 ** 18) - (2 ** 4);
  localparam int WATCHDOG_SHORT_CYCLES = (2 ** 13) - (2 ** 4);
  localparam int COUNT_WIDTH           = 18;
endpackage

/* File: design/option_decode.sv */
// option_decode: turns the two general option bytes into control levels
// assumes option bytes are constant; outputs are pure combinational
module option_decode (
  input  wire logic [7:0]  option_a,
  input  wire logic [7:0]  option_b,
  input  wire logic        nvm_protect_bit,
  input  wire logic        monitor_mode,
  input  wire logic        security_code_ok,
  output logic             supervisor_powered,
  output logic             supervisor_active_in_stop,
  output logic             supervisor_reset_allowed,
  output logic             rom_dump_block,
  output logic             stop_legal,
  output logic             watchdog_enabled,
  output logic [17:0]      recovery_cycles,
  output logic [17:0]      watchdog_cycles,
  output logic             divider_from_bus_clock,
  output logic             nvm_protected,
  output logic             nvm_monitor_lock
);
  always_comb begin
    supervisor_powered = !option_a[option_pkg::BIT_SUPERVISOR_POWER_DISABLE];
    supervisor_active_in_stop = supervisor_powered
                                && option_a[option_pkg::BIT_SUPERVISOR_IN_STOP];
    supervisor_reset_allowed = !option_a[option_pkg::BIT_SUPERVISOR_RESET_DISABLE];
    rom_dump_block = option_a[option_pkg::BIT_ROM_PROTECT];
    stop_legal = option_a[option_pkg::BIT_STOP_ENABLE];
    watchdog_enabled = !option_a[option_pkg::BIT_WATCHDOG_DISABLE];
    recovery_cycles = option_a[option_pkg::BIT_SHORT_RECOVERY]
                      ? 18'(option_pkg::RECOVERY_SHORT_CYCLES)
                      : 18'(option_pkg::RECOVERY_LONG_CYCLES);
    watchdog_cycles = option_a[option_pkg::BIT_WATCHDOG_RATE]
                      ? 18'(option_pkg::WATCHDOG_LONG_CYCLES)
                      : 18'(option_pkg::WATCHDOG_SHORT_CYCLES);
    divider_from_bus_clock = option_b[option_pkg::BIT_DIVIDER_CLOCK_SELECT];
    nvm_protected = option_b[option_pkg::BIT_NVM_SECURITY_ENABLE] && !nvm_protect_bit;
    nvm_monitor_lock = option_b[option_pkg::BIT_MONITOR_NVM_SECURITY]
                       && monitor_mode && !security_code_ok;
  end
endmodule // option_decode

/* File: design/timebase_divider.sv */
// timebase_divider: read/write divider pair reloaded from option bytes
// assumes lock and latch levels come from logic on the same clock
module timebase_divider (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reload_high,
  input  wire logic [7:0]  reload_low,
  input  wire logic        write_high,
  input  wire logic        write_low,
  input  wire logic [7:0]  write_data,
  input  wire logic        latch_active,
  output logic [7:0]       divider_high_q,
  output logic [7:0]       divider_low_q
);
  logic writable;
  // top bit of high byte is the security-disable flag; value locked when clear
  assign writable = !latch_active && divider_high_q[7];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      divider_high_q <= reload_high;
      divider_low_q  <= reload_low;
    end else begin
      if (write_high && writable) begin
        divider_high_q <= write_data;
      end
      if (write_low && writable) begin
        divider_low_q <= write_data;
      end
    end
  end
endmodule // timebase_divider

/* File: design/factory_option_registers.sv */
// factory_option_registers: fixed option bank, decoded controls, divider pair
// assumes a single-cycle strobe bus on clock; read data one cycle later
//
// Behaviour
// - four option registers are fixed read-only values feeding option setup
// - general option a at 001F, general option b at 003F
// - divider option high at FE10, low at FE11
// - stop-operation bit keeps supervisor running in stop while powered
// - rom protect bit blocks dumping after failed monitor bypass
// - reset-disable bit blocks the supervisor reset output
// - power-disable bit switches the supervisor off
// - short recovery selects 32 versus 4096 cycle stop exit
// - watchdog rate selects long or short timeout
// - stop instruction illegal unless stop-enable is set
// - watchdog-disable bit turns the watchdog off
// - divider clock from bus clock when set, oscillator otherwise
// - nvm security follows protect bit only when enabled
// - monitor mode locks nvm until a valid code
// - divider option bytes give divider reset values
// - divider option bytes copied into divider registers on reset
//
// Strobed register access is this design's own decision.
module factory_option_registers #(
  parameter logic [7:0] GENERAL_A = option_pkg::GENERAL_A_VALUE,
  parameter logic [7:0] GENERAL_B = option_pkg::GENERAL_B_VALUE,
  parameter logic [7:0] DIV_HIGH  = option_pkg::DIV_HIGH_VALUE,
  parameter logic [7:0] DIV_LOW   = option_pkg::DIV_LOW_VALUE
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [15:0] address,
  input  wire logic [7:0]  write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic [7:0]       read_data,
  input  wire logic        monitor_mode,
  input  wire logic        security_code_ok,
  input  wire logic        latch_active,
  output logic             supervisor_powered,
  output logic             supervisor_active_in_stop,
  output logic             supervisor_reset_allowed,
  output logic             rom_dump_block,
  output logic             stop_legal,
  output logic             watchdog_enabled,
  output logic [17:0]      recovery_cycles,
  output logic [17:0]      watchdog_cycles,
  output logic             divider_from_bus_clock,
  output logic             nvm_protected,
  output logic             nvm_monitor_lock,
  output logic [7:0]       divider_high,
  output logic [7:0]       divider_low
);
  // nvm configuration byte; held here so the protect bit has a home
  logic [7:0]  nvm_config_q;
  logic [7:0]  read_data_q;
  logic [7:0]  div_high_q;
  logic [7:0]  div_low_q;
  logic        pwr_d;
  logic        stop_act_d;
  logic        rst_ok_d;
  logic        rom_d;
  logic        stop_ok_d;
  logic        wdog_d;
  logic [17:0] rec_d;
  logic [17:0] wdt_d;
  logic        bus_clk_d;
  logic        prot_d;
  logic        mon_d;
  logic        pwr_q;
  logic        stop_act_q;
  logic        rst_ok_q;
  logic        rom_q;
  logic        stop_ok_q;
  logic        wdog_q;
  logic [17:0] rec_q;
  logic [17:0] wdt_q;
  logic        bus_clk_q;
  logic        prot_q;
  logic        mon_q;
  logic        mon_sync1_q;
  logic        mon_sync2_q;
  logic        code_sync1_q;
  logic        code_sync2_q;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  // monitor mode and code status arrive from pins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mon_sync1_q  <= 1'b0;
      mon_sync2_q  <= 1'b0;
      code_sync1_q <= 1'b0;
      code_sync2_q <= 1'b0;
    end else begin
      mon_sync1_q  <= monitor_mode;
      mon_sync2_q  <= mon_sync1_q;
      code_sync1_q <= security_code_ok;
      code_sync2_q <= code_sync1_q;
    end
  end

  // nvm config reset value is the factory-programmed byte
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nvm_config_q <= option_pkg::NVM_CONFIG_RESET;
    end else if (write_strobe && hit(address, option_pkg::ADDR_NVM_CONFIG)) begin
      nvm_config_q <= write_data;
    end
  end

  option_decode u_decode (
    .option_a                  (GENERAL_A),
    .option_b                  (GENERAL_B),
    .nvm_protect_bit           (nvm_config_q[option_pkg::BIT_NVM_PROTECT]),
    .monitor_mode              (mon_sync2_q),
    .security_code_ok          (code_sync2_q),
    .supervisor_powered        (pwr_d),
    .supervisor_active_in_stop (stop_act_d),
    .supervisor_reset_allowed  (rst_ok_d),
    .rom_dump_block            (rom_d),
    .stop_legal                (stop_ok_d),
    .watchdog_enabled          (wdog_d),
    .recovery_cycles           (rec_d),
    .watchdog_cycles           (wdt_d),
    .divider_from_bus_clock    (bus_clk_d),
    .nvm_protected             (prot_d),
    .nvm_monitor_lock          (mon_d)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pwr_q      <= 1'b0;
      stop_act_q <= 1'b0;
      rst_ok_q   <= 1'b0;
      rom_q      <= 1'b0;
      stop_ok_q  <= 1'b0;
      wdog_q     <= 1'b0;
      rec_q      <= 18'h0_0000;
      wdt_q      <= 18'h0_0000;
      bus_clk_q  <= 1'b0;
      prot_q     <= 1'b0;
      mon_q      <= 1'b0;
    end else begin
      pwr_q      <= pwr_d;
      stop_act_q <= stop_act_d;
      rst_ok_q   <= rst_ok_d;
      rom_q      <= rom_d;
      stop_ok_q  <= stop_ok_d;
      wdog_q     <= wdog_d;
      rec_q      <= rec_d;
      wdt_q      <= wdt_d;
      bus_clk_q  <= bus_clk_d;
      prot_q     <= prot_d;
      mon_q      <= mon_d;
    end
  end

  assign supervisor_powered        = pwr_q;
  assign supervisor_active_in_stop = stop_act_q;
  assign supervisor_reset_allowed  = rst_ok_q;
  assign rom_dump_block            = rom_q;
  assign stop_legal                = stop_ok_q;
  assign watchdog_enabled          = wdog_q;
  assign recovery_cycles           = rec_q;
  assign watchdog_cycles           = wdt_q;
  assign divider_from_bus_clock    = bus_clk_q;
  assign nvm_protected             = prot_q;
  assign nvm_monitor_lock          = mon_q;

  // the pair has its own addresses: a write to an option byte must stay inert
  // divider reset values
  timebase_divider u_divider (
    .clock          (clock),
    .reset_n        (reset_n),
    .reload_high    (DIV_HIGH),
    .reload_low     (DIV_LOW),
    .write_high     (write_strobe && hit(address, option_pkg::ADDR_DIVIDER_REG_HIGH)),
    .write_low      (write_strobe && hit(address, option_pkg::ADDR_DIVIDER_REG_LOW)),
    .write_data     (write_data),
    .latch_active   (latch_active),
    .divider_high_q (div_high_q),
    .divider_low_q  (div_low_q)
  );
  assign divider_high = div_high_q;
  assign divider_low  = div_low_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read_data_q <= 8'h00;
    end else if (read_strobe) begin
      if (hit(address, option_pkg::ADDR_GENERAL_A)) begin
        read_data_q <= GENERAL_A;
      end else if (hit(address, option_pkg::ADDR_GENERAL_B)) begin
        read_data_q <= GENERAL_B;
      end else if (hit(address, option_pkg::ADDR_DIV_HIGH)) begin
        read_data_q <= DIV_HIGH;
      end else if (hit(address, option_pkg::ADDR_DIV_LOW)) begin
        read_data_q <= DIV_LOW;
      end else if (hit(address, option_pkg::ADDR_NVM_CONFIG)) begin
        read_data_q <= nvm_config_q;
      end else if (hit(address, option_pkg::ADDR_DIVIDER_REG_HIGH)) begin
        read_data_q <= div_high_q;
      end else if (hit(address, option_pkg::ADDR_DIVIDER_REG_LOW)) begin
        read_data_q <= div_low_q;
      end else begin
        // unmapped reads return zero
        read_data_q <= 8'h00;
      end
    end else begin
      read_data_q <= 8'h00;
    end
  end
  assign read_data = read_data_q;

  a_read_general_a :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_GENERAL_A) |=> read_data == GENERAL_A)
    else $error("general option a read wrong");

  a_read_div_low :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_DIV_LOW) |=> read_data == DIV_LOW)
    else $error("divider option low read wrong");

  a_read_stable :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_GENERAL_B) ##1
      read_strobe && hit(address, option_pkg::ADDR_GENERAL_B) |=> $stable(read_data))
    else $error("option read changed");

  a_supervisor_stop :
    assert property (@(posedge clock) disable iff (!reset_n)
      supervisor_active_in_stop |-> supervisor_powered)
    else $error("supervisor in stop while unpowered");

  a_recovery_sel :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |-> recovery_cycles == (GENERAL_A[option_pkg::BIT_SHORT_RECOVERY]
        ? 18'(option_pkg::RECOVERY_SHORT_CYCLES) : 18'(option_pkg::RECOVERY_LONG_CYCLES)))
    else $error("recovery delay wrong");

  a_watchdog_sel :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |-> watchdog_cycles == (GENERAL_A[option_pkg::BIT_WATCHDOG_RATE]
        ? 18'(option_pkg::WATCHDOG_LONG_CYCLES) : 18'(option_pkg::WATCHDOG_SHORT_CYCLES)))
    else $error("watchdog timeout wrong");

  a_stop_legal :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |-> stop_legal == GENERAL_A[option_pkg::BIT_STOP_ENABLE])
    else $error("stop legality wrong");

  a_divider_reload :
    assert property (@(posedge clock)
      !reset_n |=> divider_high == DIV_HIGH && divider_low == DIV_LOW)
    else $error("divider not reloaded");

  a_monitor_lock :
    assert property (@(posedge clock) disable iff (!reset_n)
      nvm_monitor_lock |-> GENERAL_B[option_pkg::BIT_MONITOR_NVM_SECURITY])
    else $error("monitor lock without option");

  // decoded levels lag the option bytes by one register stage
  a_power_gate :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        supervisor_powered == !GENERAL_A[option_pkg::BIT_SUPERVISOR_POWER_DISABLE])
    else $error("supervisor power level wrong");

  a_reset_block :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        supervisor_reset_allowed == !GENERAL_A[option_pkg::BIT_SUPERVISOR_RESET_DISABLE])
    else $error("supervisor reset permission wrong");

  a_rom_protect :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        rom_dump_block == GENERAL_A[option_pkg::BIT_ROM_PROTECT])
    else $error("rom protection level wrong");

  a_watchdog_off :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        watchdog_enabled == !GENERAL_A[option_pkg::BIT_WATCHDOG_DISABLE])
    else $error("watchdog enable level wrong");

  a_divider_clock :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        divider_from_bus_clock == GENERAL_B[option_pkg::BIT_DIVIDER_CLOCK_SELECT])
    else $error("divider clock source wrong");

  // protect bit is read one cycle before the level shows
  a_nvm_protect :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) |->
        nvm_protected == (GENERAL_B[option_pkg::BIT_NVM_SECURITY_ENABLE]
                          && !$past(nvm_config_q[option_pkg::BIT_NVM_PROTECT])))
    else $error("nvm protection level wrong");

  a_monitor_set :
    assert property (@(posedge clock) disable iff (!reset_n)
      $past(reset_n) && $past(mon_sync2_q) && !$past(code_sync2_q) |->
        nvm_monitor_lock == GENERAL_B[option_pkg::BIT_MONITOR_NVM_SECURITY])
    else $error("monitor lock missing");

  a_read_general_b :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_GENERAL_B) |=> read_data == GENERAL_B)
    else $error("general option b read wrong");

  a_read_div_high :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_DIV_HIGH) |=> read_data == DIV_HIGH)
    else $error("divider option high read wrong");

  // read data stands one cycle only, so a stale byte never looks valid
  a_read_idle :
    assert property (@(posedge clock) disable iff (!reset_n)
      !read_strobe |=> read_data == 8'h00)
    else $error("read data outside its cycle");

  a_option_write :
    assert property (@(posedge clock) disable iff (!reset_n)
      write_strobe && (hit(address, option_pkg::ADDR_GENERAL_A)
                       || hit(address, option_pkg::ADDR_GENERAL_B)
                       || hit(address, option_pkg::ADDR_DIV_HIGH)
                       || hit(address, option_pkg::ADDR_DIV_LOW)) |=>
        $stable(divider_high) && $stable(divider_low) && $stable(nvm_config_q))
    else $error("option write had an effect");

  a_div_reg_high :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_DIVIDER_REG_HIGH) |=>
        read_data == $past(divider_high))
    else $error("divider high read back wrong");

  a_div_reg_low :
    assert property (@(posedge clock) disable iff (!reset_n)
      read_strobe && hit(address, option_pkg::ADDR_DIVIDER_REG_LOW) |=>
        read_data == $past(divider_low))
    else $error("divider low read back wrong");

  // a locked pair must hold even its own unlock bit
  a_divider_lock :
    assert property (@(posedge clock) disable iff (!reset_n)
      write_strobe && (latch_active || !divider_high[7]) |=>
        $stable(divider_high) && $stable(divider_low))
    else $error("locked divider changed");
endmodule // factory_option_registers

/* File: bench/testbench.sv */
// testbench: self-checking bench for the factory option bank, two option sets
// assumes option_pkg and the option bank with its assertions are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // second set uses short recovery: taken as a non-crystal part
  localparam logic [7:0] GA [2] = '{8'ha5, 8'h5a};
  localparam logic [7:0] GB [2] = '{8'ha0, 8'h40};
  localparam logic [7:0] DH [2] = '{8'h80, 8'h81};
  localparam logic [7:0] DL [2] = '{8'hac, 8'h23};

  logic        clock;
  logic        reset_n;
  logic [15:0] address;
  logic [7:0]  write_data;
  logic        write_strobe;
  logic        read_strobe;
  logic        monitor_mode;
  logic        security_code_ok;
  logic        latch_active;
  logic [7:0]  rd [2];
  logic        pwr [2];
  logic        in_stop [2];
  logic        rst_ok [2];
  logic        dump_blk [2];
  logic        stop_ok [2];
  logic        wd_en [2];
  logic [17:0] rec [2];
  logic [17:0] wdc [2];
  logic        bus_clk [2];
  logic        nvm_prot [2];
  logic        mon_lock [2];
  logic [7:0]  dvh [2];
  logic [7:0]  dvl [2];
  logic [7:0]  mh [2];
  logic [7:0]  ml [2];
  logic [7:0]  nvm_cfg;
  int          miscompares;
  int          n_checks;

  for (genvar i = 0; i < 2; i++) begin : g_dut
    factory_option_registers #(
      .GENERAL_A (GA[i]),
      .GENERAL_B (GB[i]),
      .DIV_HIGH  (DH[i]),
      .DIV_LOW   (DL[i])
    ) dut_u (
      .clock                     (clock),
      .reset_n                   (reset_n),
      .address                   (address),
      .write_data                (write_data),
      .write_strobe              (write_strobe),
      .read_strobe               (read_strobe),
      .read_data                 (rd[i]),
      .monitor_mode              (monitor_mode),
      .security_code_ok          (security_code_ok),
      .latch_active              (latch_active),
      .supervisor_powered        (pwr[i]),
      .supervisor_active_in_stop (in_stop[i]),
      .supervisor_reset_allowed  (rst_ok[i]),
      .rom_dump_block            (dump_blk[i]),
      .stop_legal                (stop_ok[i]),
      .watchdog_enabled          (wd_en[i]),
      .recovery_cycles           (rec[i]),
      .watchdog_cycles           (wdc[i]),
      .divider_from_bus_clock    (bus_clk[i]),
      .nvm_protected             (nvm_prot[i]),
      .nvm_monitor_lock          (mon_lock[i]),
      .divider_high              (dvh[i]),
      .divider_low               (dvl[i])
    );
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check_count(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count({10'h000, got}, {10'h000, exp});
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_count({17'h0_0000, got}, {17'h0_0000, exp});
  endtask

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    if (a == 16'hfe1c) nvm_cfg = d;
    // divider pair writable only unlatched and with security disabled
    for (int i = 0; i < 2; i++) begin
      if (!latch_active && mh[i][7] && a == option_pkg::ADDR_DIVIDER_REG_HIGH) mh[i] = d;
      else if (!latch_active && mh[i][7] && a == option_pkg::ADDR_DIVIDER_REG_LOW) ml[i] = d;
    end
  endtask

  task automatic bus_read(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1,
                          input int reps = 1);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    // back-to-back reads keep the strobe up between them
    for (int k = 0; k < reps; k++) begin
      @(posedge clock);
      if (k == reps - 1) read_strobe <= 1'b0;
      #1;
      check_byte(rd[0], e0);
      check_byte(rd[1], e1);
    end
    @(posedge clock);
    #1;
    check_byte(rd[0], 8'h00);
    check_byte(rd[1], 8'h00);
  endtask

  task automatic check_div();
    #1;
    for (int i = 0; i < 2; i++) begin
      check_byte(dvh[i], mh[i]);
      check_byte(dvl[i], ml[i]);
    end
  endtask

  // bit layout as chosen by the design: a[7..0], b[7..5], config bit 4
  task automatic check_decoded();
    for (int i = 0; i < 2; i++) begin
      check_flag(pwr[i], !GA[i][4]);
      check_flag(in_stop[i], !GA[i][4] && GA[i][7]);
      check_flag(rst_ok[i], !GA[i][5]);
      check_flag(dump_blk[i], GA[i][6]);
      check_flag(stop_ok[i], GA[i][1]);
      check_flag(wd_en[i], !GA[i][0]);
      check_count(rec[i], GA[i][3] ? 18'h0_0020 : 18'h0_1000);
      check_count(wdc[i], GA[i][2] ? 18'h3_fff0 : 18'h0_1ff0);
      check_flag(bus_clk[i], GB[i][7]);
      check_flag(nvm_prot[i], GB[i][6] && !nvm_cfg[4]);
      check_flag(mon_lock[i], GB[i][5] && monitor_mode && !security_code_ok);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    nvm_cfg = 8'h10;
    mh      = DH;
    ml      = DL;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // settle the synchronised pins before judging the decoded levels
  task automatic settle_and_check();
    repeat (6) @(posedge clock);
    #1;
    check_decoded();
  endtask

  task automatic results();
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    results();
  end

  initial begin
    reset_n          = 1'b0;
    address          = 16'h0000;
    write_data       = 8'h00;
    write_strobe     = 1'b0;
    read_strobe      = 1'b0;
    monitor_mode     = 1'b0;
    security_code_ok = 1'b0;
    latch_active     = 1'b0;
    miscompares      = 0;
    n_checks         = 0;
    do_reset();
    check_decoded();
    bus_read(16'h001f, GA[0], GA[1]);
    bus_read(16'h003f, GB[0], GB[1]);
    bus_read(16'hfe10, DH[0], DH[1]);
    bus_read(16'hfe11, DL[0], DL[1]);
    bus_read(16'h0020, 8'h00, 8'h00);
    bus_write(16'h001f, ~GA[0]);
    bus_write(16'h003f, ~GB[0]);
    bus_read(16'h001f, GA[0], GA[1]);
    bus_read(16'h003f, GB[0], GB[1], 2);
    check_div();
    latch_active <= 1'b1;
    bus_write(option_pkg::ADDR_DIVIDER_REG_LOW, 8'h5c);
    latch_active <= 1'b0;
    check_div();
    bus_write(option_pkg::ADDR_DIVIDER_REG_LOW, 8'h5c);
    check_div();
    bus_write(16'hfe11, 8'h3e);
    bus_write(16'hfe10, 8'h00);
    check_div();
    bus_read(16'hfe11, DL[0], DL[1]);
    bus_read(option_pkg::ADDR_DIVIDER_REG_LOW, ml[0], ml[1]);
    // clearing the security-disable bit locks the pair
    bus_write(option_pkg::ADDR_DIVIDER_REG_HIGH, 8'h05);
    bus_write(option_pkg::ADDR_DIVIDER_REG_LOW, 8'h77);
    check_div();
    bus_read(option_pkg::ADDR_DIVIDER_REG_HIGH, mh[0], mh[1]);
    bus_write(16'hfe1c, 8'h00);
    monitor_mode <= 1'b1;
    settle_and_check();
    security_code_ok <= 1'b1;
    settle_and_check();
    monitor_mode     <= 1'b0;
    security_code_ok <= 1'b0;
    settle_and_check();
    do_reset();
    check_div();
    check_decoded();
    results();
  end
endmodule // testbench
